// [include/tcau_pkg.sv]
// Purpose: Shared constants and types for the texture coordinate address unit
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes: Coordinates use 10.2 screen, 10.5 start and s5.10 step fixed point
package tcau_pkg;
   // Register byte offsets
   localparam logic [7:0] TCAU_CTRL_OFS = 8'h00;
   localparam logic [7:0] TCAU_RECT0_OFS = 8'h04;
   localparam logic [7:0] TCAU_RECT1_OFS = 8'h08;
   localparam logic [7:0] TCAU_START_OFS = 8'h0c;
   localparam logic [7:0] TCAU_STEP_OFS = 8'h10;
   localparam logic [7:0] TCAU_TILE_S_OFS = 8'h14;
   localparam logic [7:0] TCAU_TILE_T_OFS = 8'h18;
   localparam logic [7:0] TCAU_ALPHA_OFS = 8'h1c;
   localparam logic [7:0] TCAU_STATUS_OFS = 8'h20;
   // Control fields
   localparam int TCAU_CTRL_GO_BIT = 0;
   localparam int TCAU_CTRL_SWAP_BIT = 1;
   // Rectangle corner: x in low half, y in high half, 10.2 each
   localparam int TCAU_XY_W = 12;
   localparam int TCAU_Y_LSB = 16;
   // Start and step: s in low half, t in high half
   localparam int TCAU_T_LSB = 16;
   // Tile descriptor fields
   localparam int TCAU_LOW_LSB = 0;
   localparam int TCAU_HIGH_LSB = 12;
   localparam int TCAU_MASK_LSB = 24;
   localparam int TCAU_MIRROR_BIT = 28;
   localparam int TCAU_CLAMP_BIT = 29;
   // Alpha configuration fields
   localparam int TCAU_AREF_LSB = 0;
   localparam int TCAU_ONEBIT_BIT = 8;
   localparam int TCAU_CMP_BIT = 9;
   localparam int TCAU_RAND_BIT = 10;
   // Reset values
   localparam logic [31:0] TCAU_STEP_RST = 32'h0400_0400;
   localparam logic [31:0] TCAU_ZERO_RST = 32'h0000_0000;
   localparam logic [7:0] TCAU_LFSR_SEED = 8'h5a;
   // Fixed point
   localparam int TCAU_ACC_W = 22;
   localparam int TCAU_FRAC_W = 10;
   // Bus responses
   localparam logic [1:0] TCAU_RESP_OKAY = 2'h0;
   localparam logic [1:0] TCAU_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      TCAU_IDLE = 2'b01,
      TCAU_RUN = 2'b10
   } tcau_state_t;
endpackage

// [logic/tcau_top.sv]
// Purpose: Walks a screen-aligned texture rectangle and emits texel addresses and pixel write decisions
// Assumes: One clock, registers over AXI4-Lite, texel alpha returned by texture memory
// Notes: All state lives in one struct; outputs come straight from its flip-flops
//
// Contract
// - With reflect on and mask 5, texels run backwards while the coordinate is 32 to 63.
// - With reflect off, texels run forwards in every repetition period.
// - A non-zero mask with edge-hold clear repeats the texture, with no extra flag.
// - A mask value from 1 to 10 is the power-of-two exponent of the repetition period; masks 11 to 15 give a period of 1024.
// - Repeat and reflect together, with a mask up to 10, alternate forward and reversed copies per period.
// - High bounds are used only while edge-hold is on for that axis.
// - Low bounds are unsigned offsets subtracted from the incoming coordinate.
// - Rectangle X and Y carry two fractional bits.
// - S and T start values carry five fractional bits.
// - The per-pixel step is a signed 16-bit value, so a negative step flips the image.
// - The swapped-axis command steps T along X and S along Y.
// - A one-bit texel alpha writes the pixel fully or leaves it untouched.
// - A multi-bit texel alpha blends the pixel with the background by that alpha.
// - Alpha compare thresholds texel alpha against a register or random alpha for a write enable.
`timescale 1ns/100ps
module tcau_top
   import tcau_pkg::*;
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic PIX_VALID,
   input wire logic PIX_READY,
   output logic [9:0] PIX_X,
   output logic [9:0] PIX_Y,
   output logic [9:0] TEX_S,
   output logic [9:0] TEX_T,
   input wire logic TEXEL_VALID,
   input wire logic [7:0] TEXEL_ALPHA,
   output logic PX_VALID,
   output logic PX_WRITE,
   output logic PX_BLEND,
   output logic [7:0] PX_COEF
);

   typedef struct packed {
      tcau_state_t st;
      logic swap;
      logic [31:0] rect0;
      logic [31:0] rect1;
      logic [31:0] start;
      logic [31:0] step;
      logic [31:0] tile_s;
      logic [31:0] tile_t;
      logic [31:0] alpha_cfg;
      logic [9:0] px;
      logic [9:0] py;
      logic [9:0] xbeg;
      logic [9:0] xend;
      logic [9:0] yend;
      logic [TCAU_ACC_W-1:0] s_acc;
      logic [TCAU_ACC_W-1:0] t_acc;
      logic [TCAU_ACC_W-1:0] row_s;
      logic [TCAU_ACC_W-1:0] row_t;
      logic [7:0] lfsr;
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic pix_valid;
      logic [9:0] pix_x;
      logic [9:0] pix_y;
      logic [9:0] tex_s;
      logic [9:0] tex_t;
      logic px_valid;
      logic px_write;
      logic px_blend;
      logic [7:0] px_coef;
   } tcau_regs_t;

   tcau_regs_t st_reg;
   tcau_regs_t st_next;

   // Byte-lane merge of a register write
   function automatic logic [31:0] tcau_merge(input logic [31:0] old, input logic [31:0] din,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = din[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Start value in 10.5 widened to the 10-bit fraction of the accumulator
   function automatic logic [TCAU_ACC_W-1:0] tcau_start(input logic [15:0] v);
      return {{(TCAU_ACC_W-21){v[15]}}, v, 5'h00};
   endfunction

   // Signed s5.10 step sign-extended to the accumulator
   function automatic logic [TCAU_ACC_W-1:0] tcau_step(input logic [15:0] v);
      return {{(TCAU_ACC_W-16){v[15]}}, v};
   endfunction

   // Integer pixel from a 10.2 corner
   function automatic logic [9:0] tcau_pix(input logic [TCAU_XY_W-1:0] v);
      return v[TCAU_XY_W-1:2];
   endfunction

   // Turns one accumulated coordinate into a texel index for one tile axis
   function automatic logic [9:0] tcau_axis(input logic [TCAU_ACC_W-1:0] acc, input logic [31:0] tile);
      logic [11:0] low;
      logic [11:0] high;
      logic [3:0] mask;
      logic [TCAU_ACC_W-1:0] rel;
      logic signed [11:0] ci;
      logic [9:0] span;
      logic [9:0] mk;
      logic [9:0] v;
      low = tile[TCAU_LOW_LSB +: 12];
      high = tile[TCAU_HIGH_LSB +: 12];
      mask = tile[TCAU_MASK_LSB +: 4];
      rel = acc - {{(TCAU_ACC_W-20){1'b0}}, low, 8'h00};
      ci = $signed(rel[TCAU_ACC_W-1:TCAU_FRAC_W]);
      span = high[11:2] - low[11:2];
      mk = 10'h000;
      v = ci[9:0];
      if (tile[TCAU_CLAMP_BIT]) begin
         if (ci < 0) begin
            v = 10'h000;
         end else if (ci[10:0] > {1'b0, span}) begin
            v = span;
         end
      end else if (mask != 4'h0) begin
         mk = (mask > 4'ha) ? 10'h3ff : 10'((11'h001 << mask) - 11'h001);
         v = ci[9:0] & mk;
         if (tile[TCAU_MIRROR_BIT] && mask < 4'hb && ci[mask]) begin
            v = ~ci[9:0] & mk;
         end
      end
      return v;
   endfunction

   always_comb begin
      logic go;
      logic adv;
      logic [TCAU_ACC_W-1:0] ds;
      logic [TCAU_ACC_W-1:0] dt;
      logic [7:0] thresh;
      st_next = st_reg;
      go = 1'b0;
      adv = 1'b0;
      thresh = 8'h00;
      ds = tcau_step(st_reg.step[15:0]);
      dt = tcau_step(st_reg.step[TCAU_T_LSB +: 16]);
      st_next.lfsr = {st_reg.lfsr[6:0], st_reg.lfsr[7] ^ st_reg.lfsr[5] ^ st_reg.lfsr[4] ^ st_reg.lfsr[3]};

      // Register bus: address and data may arrive in either order
      if (S_AXI_AWVALID && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.awaddr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.wdata = S_AXI_WDATA;
         st_next.wstrb = S_AXI_WSTRB;
      end
      if (st_reg.bvalid && S_AXI_BREADY) begin
         st_next.bvalid = 1'b0;
      end
      if (st_next.aw_have && st_next.w_have && !st_next.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = TCAU_RESP_OKAY;
         case ({st_next.awaddr[7:2], 2'b00})
            TCAU_CTRL_OFS: begin
               if (st_next.wstrb[0]) begin
                  go = st_next.wdata[TCAU_CTRL_GO_BIT];
                  st_next.swap = st_next.wdata[TCAU_CTRL_SWAP_BIT];
               end
            end
            TCAU_RECT0_OFS: st_next.rect0 = tcau_merge(st_reg.rect0, st_next.wdata, st_next.wstrb);
            TCAU_RECT1_OFS: st_next.rect1 = tcau_merge(st_reg.rect1, st_next.wdata, st_next.wstrb);
            TCAU_START_OFS: st_next.start = tcau_merge(st_reg.start, st_next.wdata, st_next.wstrb);
            TCAU_STEP_OFS: st_next.step = tcau_merge(st_reg.step, st_next.wdata, st_next.wstrb);
            TCAU_TILE_S_OFS: st_next.tile_s = tcau_merge(st_reg.tile_s, st_next.wdata, st_next.wstrb);
            TCAU_TILE_T_OFS: st_next.tile_t = tcau_merge(st_reg.tile_t, st_next.wdata, st_next.wstrb);
            TCAU_ALPHA_OFS: st_next.alpha_cfg = tcau_merge(st_reg.alpha_cfg, st_next.wdata, st_next.wstrb);
            TCAU_STATUS_OFS: st_next.bresp = TCAU_RESP_OKAY;
            default: st_next.bresp = TCAU_RESP_SLVERR;
         endcase
      end

      if (st_reg.rvalid && S_AXI_RREADY) begin
         st_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = TCAU_RESP_OKAY;
         case ({S_AXI_ARADDR[7:2], 2'b00})
            TCAU_CTRL_OFS: st_next.rdata = {30'h0, st_reg.swap, 1'b0};
            TCAU_RECT0_OFS: st_next.rdata = st_reg.rect0;
            TCAU_RECT1_OFS: st_next.rdata = st_reg.rect1;
            TCAU_START_OFS: st_next.rdata = st_reg.start;
            TCAU_STEP_OFS: st_next.rdata = st_reg.step;
            TCAU_TILE_S_OFS: st_next.rdata = st_reg.tile_s;
            TCAU_TILE_T_OFS: st_next.rdata = st_reg.tile_t;
            TCAU_ALPHA_OFS: st_next.rdata = st_reg.alpha_cfg;
            TCAU_STATUS_OFS: st_next.rdata = {st_reg.py, 5'h00, st_reg.px, 6'h00, st_reg.st == TCAU_RUN};
            default: begin
               st_next.rdata = 32'h0000_0000;
               st_next.rresp = TCAU_RESP_SLVERR;
            end
         endcase
      end

      // Rectangle walk
      if (st_reg.pix_valid && PIX_READY) begin
         st_next.pix_valid = 1'b0;
      end
      adv = !st_reg.pix_valid || PIX_READY;
      case (st_reg.st)
         TCAU_IDLE: begin
            if (go && tcau_pix(st_reg.rect0[TCAU_XY_W-1:0]) < tcau_pix(st_reg.rect1[TCAU_XY_W-1:0]) &&
                tcau_pix(st_reg.rect0[TCAU_Y_LSB +: TCAU_XY_W]) < tcau_pix(st_reg.rect1[TCAU_Y_LSB +: TCAU_XY_W])) begin
               st_next.st = TCAU_RUN;
               st_next.px = tcau_pix(st_reg.rect0[TCAU_XY_W-1:0]);
               st_next.xbeg = tcau_pix(st_reg.rect0[TCAU_XY_W-1:0]);
               st_next.py = tcau_pix(st_reg.rect0[TCAU_Y_LSB +: TCAU_XY_W]);
               st_next.xend = tcau_pix(st_reg.rect1[TCAU_XY_W-1:0]);
               st_next.yend = tcau_pix(st_reg.rect1[TCAU_Y_LSB +: TCAU_XY_W]);
               st_next.s_acc = tcau_start(st_reg.start[15:0]);
               st_next.t_acc = tcau_start(st_reg.start[TCAU_T_LSB +: 16]);
               st_next.row_s = tcau_start(st_reg.start[15:0]);
               st_next.row_t = tcau_start(st_reg.start[TCAU_T_LSB +: 16]);
            end
         end
         TCAU_RUN: begin
            if (adv) begin
               st_next.pix_valid = 1'b1;
               st_next.pix_x = st_reg.px;
               st_next.pix_y = st_reg.py;
               st_next.tex_s = tcau_axis(st_reg.s_acc, st_reg.tile_s);
               st_next.tex_t = tcau_axis(st_reg.t_acc, st_reg.tile_t);
               if (st_reg.px + 10'h001 < st_reg.xend) begin
                  st_next.px = st_reg.px + 10'h001;
                  if (st_reg.swap) begin
                     st_next.t_acc = st_reg.t_acc + dt;
                  end else begin
                     st_next.s_acc = st_reg.s_acc + ds;
                  end
               end else if (st_reg.py + 10'h001 < st_reg.yend) begin
                  st_next.px = st_reg.xbeg;
                  st_next.py = st_reg.py + 10'h001;
                  if (st_reg.swap) begin
                     st_next.s_acc = st_reg.row_s + ds;
                     st_next.row_s = st_reg.row_s + ds;
                     st_next.t_acc = st_reg.row_t;
                  end else begin
                     st_next.t_acc = st_reg.row_t + dt;
                     st_next.row_t = st_reg.row_t + dt;
                     st_next.s_acc = st_reg.row_s;
                  end
               end else begin
                  st_next.st = TCAU_IDLE;
               end
            end
         end
         default: st_next.st = TCAU_IDLE;
      endcase

      // Pixel write decision from the returned texel alpha
      thresh = st_reg.alpha_cfg[TCAU_RAND_BIT] ? st_reg.lfsr : st_reg.alpha_cfg[TCAU_AREF_LSB +: 8];
      st_next.px_valid = TEXEL_VALID;
      if (TEXEL_VALID) begin
         if (st_reg.alpha_cfg[TCAU_CMP_BIT]) begin
            st_next.px_write = TEXEL_ALPHA > thresh;
            st_next.px_blend = 1'b0;
            st_next.px_coef = 8'hff;
         end else if (st_reg.alpha_cfg[TCAU_ONEBIT_BIT]) begin
            st_next.px_write = TEXEL_ALPHA[7];
            st_next.px_blend = 1'b0;
            st_next.px_coef = 8'hff;
         end else begin
            st_next.px_write = TEXEL_ALPHA != 8'h00;
            st_next.px_blend = TEXEL_ALPHA != 8'h00 && TEXEL_ALPHA != 8'hff;
            st_next.px_coef = TEXEL_ALPHA;
         end
      end

      // Address and write-data readys stay low while a write answer is pending; read ready only while a read answer is
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready = !st_next.w_have && !st_next.bvalid;
      st_next.arready = !st_next.rvalid;
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg <= '0;
         st_reg.st <= TCAU_IDLE;
         st_reg.step <= TCAU_STEP_RST;
         st_reg.alpha_cfg <= TCAU_ZERO_RST;
         st_reg.lfsr <= TCAU_LFSR_SEED;
      end else begin
         st_reg <= st_next;
      end
   end

   assign S_AXI_AWREADY = st_reg.awready;
   assign S_AXI_WREADY = st_reg.wready;
   assign S_AXI_BRESP = st_reg.bresp;
   assign S_AXI_BVALID = st_reg.bvalid;
   assign S_AXI_ARREADY = st_reg.arready;
   assign S_AXI_RDATA = st_reg.rdata;
   assign S_AXI_RRESP = st_reg.rresp;
   assign S_AXI_RVALID = st_reg.rvalid;
   assign PIX_VALID = st_reg.pix_valid;
   assign PIX_X = st_reg.pix_x;
   assign PIX_Y = st_reg.pix_y;
   assign TEX_S = st_reg.tex_s;
   assign TEX_T = st_reg.tex_t;
   assign PX_VALID = st_reg.px_valid;
   assign PX_WRITE = st_reg.px_write;
   assign PX_BLEND = st_reg.px_blend;
   assign PX_COEF = st_reg.px_coef;

endmodule

// [bench/tcau_top_properties.sv]
// Purpose: Port assertions for the texture coordinate address unit
// Assumes: One clock, RESETN active low
// Notes: Bound into tcau_top from the bench top file
`timescale 1ns/100ps
module tcau_top_properties (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic PIX_VALID,
   input wire logic PIX_READY,
   input wire logic [9:0] PIX_X,
   input wire logic [9:0] PIX_Y,
   input wire logic [9:0] TEX_S,
   input wire logic TEXEL_VALID,
   input wire logic PX_VALID,
   input wire logic PX_WRITE,
   input wire logic PX_BLEND,
   input wire logic [7:0] PX_COEF
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RESETN);
   chk_px_answer: assert property (TEXEL_VALID |=> PX_VALID)
      else $error("pixel decision missing");
   chk_px_quiet: assert property (!TEXEL_VALID |=> !PX_VALID)
      else $error("pixel decision without texel");
   chk_blend_partial: assert property (PX_VALID && PX_BLEND |-> PX_WRITE && PX_COEF != 8'hff && PX_COEF != 8'h00)
      else $error("blend with full or empty alpha");
   chk_skip_no_blend: assert property (PX_VALID && !PX_WRITE |-> !PX_BLEND)
      else $error("blend on skipped pixel");
   chk_px_data_hold: assert property (!TEXEL_VALID |=> $stable(PX_COEF) && $stable(PX_WRITE))
      else $error("pixel decision changed without texel");
   chk_pix_held: assert property (PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_X) && $stable(PIX_Y) && $stable(TEX_S))
      else $error("pixel dropped while stalled");
   chk_raster_step: assert property (PIX_VALID && PIX_READY ##1 PIX_VALID && PIX_Y == $past(PIX_Y) |-> PIX_X == $past(PIX_X) + 10'h1)
      else $error("pixel x not stepping by one");
   chk_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID && !S_AXI_AWREADY)
      else $error("write response late");
   cov_stall: cover property (PIX_VALID && !PIX_READY);
   cov_blend: cover property (PX_VALID && PX_BLEND);
   cov_write: cover property (PX_VALID && PX_WRITE && !PX_BLEND);
endmodule

// [bench/tcau_texmem.sv]
// Purpose: Texture memory and pixel consumer beside the coordinate unit
// Assumes: One texel answer per accepted pixel, one cycle later
// Notes: Alpha is a base value plus the texel S index; stall toggles ready
`timescale 1ns/100ps
module tcau_texmem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pix_valid,
   input wire logic [9:0] tex_s,
   input wire logic stall,
   input wire logic [7:0] alpha_base,
   output logic pix_ready,
   output logic texel_valid,
   output logic [7:0] texel_alpha
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_ready <= 1'b0;
         texel_valid <= 1'b0;
         texel_alpha <= 8'h00;
      end else begin
         pix_ready <= !stall || !pix_ready;
         texel_valid <= pix_valid && pix_ready;
         if (pix_valid && pix_ready) begin
            texel_alpha <= alpha_base + tex_s[7:0];
         end else begin
            // Idle bus inverts the last alpha every cycle
            texel_alpha <= ~texel_alpha;
         end
      end
   end
endmodule

// [bench/tb_texture_coord_address_unit.sv]
// Purpose: Self-checking bench for the texture coordinate address unit
// Assumes: AXI4-Lite registers, texture memory model beside the unit
// Notes: Each scenario is a task that judges its own results
`timescale 1ns/100ps
module tb_texture_coord_address_unit
   import tcau_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, stall = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00, abase = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awr, wr, bv, arr, rv, pv, prdy, tv, xv, xw, xb;
   logic [1:0] bresp, rresp;
   logic [31:0] rd;
   logic [9:0] px, py, ts, tt;
   logic [7:0] ta, xc;
   int failures = 0;
   int checked = 0;
   logic [39:0] pq[$];
   logic [9:0] xq[$];
   localparam logic [31:0] u1 = TCAU_STEP_RST;
   tcau_top uut (.CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .PIX_VALID(pv),
      .PIX_READY(prdy), .PIX_X(px), .PIX_Y(py), .TEX_S(ts), .TEX_T(tt), .TEXEL_VALID(tv), .TEXEL_ALPHA(ta),
      .PX_VALID(xv), .PX_WRITE(xw), .PX_BLEND(xb), .PX_COEF(xc));
   tcau_texmem mem (.clk(clk), .rst_n(rst_n), .pix_valid(pv), .tex_s(ts), .stall(stall), .alpha_base(abase),
      .pix_ready(prdy), .texel_valid(tv), .texel_alpha(ta));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pv && prdy) pq.push_back({px, py, ts, tt});
      if (xv) xq.push_back({xw, xb, xc});
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         $display("mismatch at %0t: wait ran out", $time);
         finish_test();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bv) break;
      end
      bound(n, 50);
      br <= 1'b0;
      check({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      bound(n, 50);
      rr <= 1'b0;
      check(rd, ed);
      check({30'h0, rresp}, {30'h0, er});
   endtask
   function automatic logic [31:0] tl(input int cl, input int mi, input int m, input int hi, input int lo);
      return {2'b00, 1'(cl), 1'(mi), 4'(m), 10'(hi), 2'b00, 10'(lo), 2'b00};
   endfunction
   task automatic run(input logic [9:0] w, input logic [9:0] h, input logic [31:0] st, input logic [31:0] sp,
                      input logic [31:0] tls, input logic swp, input logic [9:0] es[$], input logic [9:0] et[$]);
      int n;
      pq.delete();
      xq.delete();
      axw(TCAU_RECT0_OFS, {4'h0, 10'd20, 2'b10, 4'h0, 10'd10, 2'b11}, TCAU_RESP_OKAY);
      axw(TCAU_RECT1_OFS, {4'h0, 10'd20 + h, 2'b00, 4'h0, 10'd10 + w, 2'b00}, TCAU_RESP_OKAY);
      axw(TCAU_START_OFS, st, TCAU_RESP_OKAY);
      axw(TCAU_STEP_OFS, sp, TCAU_RESP_OKAY);
      axw(TCAU_TILE_S_OFS, tls, TCAU_RESP_OKAY);
      axw(TCAU_CTRL_OFS, {30'h0, swp, 1'b1}, TCAU_RESP_OKAY);
      for (n = 0; n < 200 && pq.size() < es.size(); n++) @(posedge clk);
      bound(n, 200);
      repeat (5) @(posedge clk);
      check(pq.size(), es.size());
      for (n = 0; n < es.size() && n < pq.size(); n++) begin
         check(32'(pq[n][39:20]), 32'({10'd10 + 10'(n % w), 10'd20 + 10'(n / w)}));
         check(32'(pq[n][19:0]), 32'({es[n], et[n]}));
      end
   endtask
   task automatic test_regs();
      axr(TCAU_STEP_OFS, TCAU_STEP_RST, TCAU_RESP_OKAY);
      axr(8'h40, 32'h0, TCAU_RESP_SLVERR);
      axw(8'h40, 32'hffffffff, TCAU_RESP_SLVERR);
      axw(TCAU_TILE_T_OFS, 32'h0, TCAU_RESP_OKAY);
      axw(TCAU_ALPHA_OFS, 32'h155, TCAU_RESP_OKAY);
      axr(TCAU_ALPHA_OFS, 32'h155, TCAU_RESP_OKAY);
      $display("test regs done");
   endtask
   task automatic test_repeat();
      stall <= 1'b1;
      // Reflection only on power-of-two extents
      run(4, 1, 32'h400, u1, tl(0, 1, 5, 0, 0), 1'b0, '{31, 30, 29, 28}, '{0, 0, 0, 0});
      stall <= 1'b0;
      run(4, 1, 32'h400, u1, tl(0, 0, 5, 0, 0), 1'b0, '{0, 1, 2, 3}, '{0, 0, 0, 0});
      run(4, 1, 32'h7c0, u1, tl(0, 1, 5, 0, 0), 1'b0, '{1, 0, 0, 1}, '{0, 0, 0, 0});
      run(4, 1, 32'h40, u1, tl(0, 0, 2, 0, 0), 1'b0, '{2, 3, 0, 1}, '{0, 0, 0, 0});
      $display("test repeat done");
   endtask
   task automatic test_bounds();
      run(5, 1, 32'h60, u1, tl(1, 0, 0, 6, 4), 1'b0, '{0, 0, 1, 2, 2}, '{0, 0, 0, 0, 0});
      run(5, 1, 32'h60, u1, tl(0, 0, 0, 1, 4), 1'b0, '{1023, 0, 1, 2, 3}, '{0, 0, 0, 0, 0});
      $display("test bounds done");
   endtask
   task automatic test_flip();
      run(2, 2, 32'hb0, 32'h0400fc00, 32'h0, 1'b0, '{5, 4, 5, 4}, '{0, 0, 1, 1});
      run(2, 2, 32'hb0, 32'h0400fc00, 32'h0, 1'b1, '{5, 5, 4, 4}, '{0, 1, 0, 1});
      $display("test flip done");
   endtask
   task automatic test_alpha();
      logic [31:0] at [8] = '{32'h280800ff, 32'h280812ff, 32'h100802ff, 32'h1007f0ff,
                              32'h00040340, 32'h000ff2ff, 32'h00000000, 32'h600000ff};
      int i;
      for (i = 0; i < 8; i++) begin
         // Alpha mode and alpha base setup for this compare, one-bit or blend case
         abase <= at[i][19:12];
         axw(TCAU_ALPHA_OFS, {20'h0, at[i][31:20]}, TCAU_RESP_OKAY);
         run(1, 1, 32'h0, u1, 32'h0, 1'b0, '{0}, '{0});
         check(xq.size(), 1);
         check({22'h0, xq[$]}, {22'h0, at[i][9:0]});
      end
      $display("test alpha done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      test_regs();
      test_repeat();
      test_bounds();
      test_flip();
      test_alpha();
      finish_test();
   end
endmodule
bind tcau_top tcau_top_properties chk (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_X(PIX_X), .PIX_Y(PIX_Y),
   .TEX_S(TEX_S), .TEXEL_VALID(TEXEL_VALID), .PX_VALID(PX_VALID), .PX_WRITE(PX_WRITE), .PX_BLEND(PX_BLEND),
   .PX_COEF(PX_COEF));
